// ===== rtl/wca_core.sv
`timescale 1ns/10ps
// Summary of operation
// - the fixed word 00 0000 0110 0100 decodes as the watchdog kick.
// - a kick loads the watchdog counter with zero.
// - a kick also clears the watchdog prescaler; the free-running tick divider is not reset.
// - a kick sets timeout and sleep status flags, touching no other bits.
// - decrement subtracts one from the file register at the 7-bit address.
// - decrement target bit 0 writes working register, 1 writes file register.
// - literal subtract computes literal minus working register, two's complement.
// - pattern 11 110x with 8-bit literal is literal subtract; x ignored.
// - literal subtract always writes its result to the working register.
// - file subtract is file minus working; target bit picks destination.
// - after a subtract, carry is 1 when the result is positive.
// - after a subtract, carry is 1 when the result is zero.
// - after a subtract, carry is 0 on borrow and the byte wraps.
module wca_core
  import wca_pkg::*;
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic            instr_valid,
  input  wire logic [13:0]     instr,
  output logic [6:0]           freg_raddr,
  input  wire logic [7:0]      freg_rdata,
  output logic                 freg_we,
  output logic [6:0]           freg_waddr,
  output logic [7:0]           freg_wdata,
  output logic                 op_done,
  output logic                 wdt_kick,
  output logic                 wdt_expired
);
  import wca_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  wca_op_e        dec_op;
  logic           dec_dest;
  logic [6:0]     dec_addr;
  logic [7:0]     dec_lit;
  wca_op_e        ex_op_r;
  logic           ex_dest_r;
  logic [7:0]     ex_lit_r;
  logic [7:0]     w_r;
  logic [4:0]     status_r;
  logic [1:0]     ctrl_r;
  logic [7:0]     wdt_cnt_r;
  logic [7:0]     presc_r;
  logic [7:0]     tick_cnt_r;
  logic           tick;
  logic [7:0]     file_val;
  logic [7:0]     alu_a;
  logic [7:0]     alu_res;
  logic           alu_c;
  logic           alu_hb;
  logic           alu_z;
  logic           ex_sub;
  logic           ex_wr_w;
  logic           ex_wr_f;
  logic           apb_wr;
  logic           apb_setup;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready && pwrite;

  // ----------------------------------------------------------------
  // decode stage
  // ----------------------------------------------------------------
  wca_decode u_decode (
    .instr (instr),
    .op    (dec_op),
    .dest  (dec_dest),
    .addr  (dec_addr),
    .lit   (dec_lit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ex_op_r    <= OP_NONE;
      ex_dest_r  <= 1'b0;
      ex_lit_r   <= 8'h00;
      freg_raddr <= 7'h00;
    end else begin
      ex_op_r    <= (instr_valid && ctrl_r[CTRL_EXEC]) ? dec_op : OP_NONE;
      ex_dest_r  <= dec_dest;
      ex_lit_r   <= dec_lit;
      freg_raddr <= dec_addr;
    end
  end

  // ----------------------------------------------------------------
  // execute stage
  // ----------------------------------------------------------------
  // forward the previous write-back, the file has not stored it yet
  assign file_val = (freg_we && freg_waddr == freg_raddr) ? freg_wdata : freg_rdata;
  assign alu_a    = (ex_op_r == OP_SUBL) ? ex_lit_r : file_val;
  assign ex_sub   = (ex_op_r == OP_SUBL) || (ex_op_r == OP_SUBF);
  assign ex_wr_w  = (ex_op_r == OP_SUBL)
                 || ((ex_op_r == OP_DEC || ex_op_r == OP_SUBF) && !ex_dest_r);
  assign ex_wr_f  = (ex_op_r == OP_DEC || ex_op_r == OP_SUBF) && ex_dest_r;

  wca_alu u_alu (
    .op    (ex_op_r),
    .a     (alu_a),
    .w     (w_r),
    .res   (alu_res),
    .carry (alu_c),
    .half  (alu_hb),
    .zero  (alu_z)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_r <= 8'h00;
    end else if (ex_wr_w) begin
      w_r <= alu_res;
    end else if (apb_wr && paddr == ADDR_WREG) begin
      w_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freg_we    <= 1'b0;
      freg_waddr <= 7'h00;
      freg_wdata <= 8'h00;
      op_done    <= 1'b0;
    end else begin
      freg_we    <= ex_wr_f;
      freg_waddr <= freg_raddr;
      freg_wdata <= alu_res;
      op_done    <= (ex_op_r != OP_NONE);
    end
  end

  // ----------------------------------------------------------------
  // status register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= STATUS_RST;
    end else if (ex_op_r == OP_KICK) begin
      status_r[ST_TIMEOUT] <= 1'b1;
      status_r[ST_SLEEP]   <= 1'b1;
    end else begin
      if (ex_sub) begin
        status_r[ST_C]  <= alu_c;
        status_r[ST_HB] <= alu_hb;
        status_r[ST_Z]  <= alu_z;
      end else if (ex_op_r == OP_DEC) begin
        status_r[ST_Z] <= alu_z;
      end else if (apb_wr && paddr == ADDR_STATUS) begin
        status_r <= pwdata[4:0];
      end
      // expiry is a one-cycle pulse: it must not be lost behind an alu op
      if (wdt_expired) begin
        status_r[ST_TIMEOUT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // watchdog counter and prescaler
  // ----------------------------------------------------------------
  assign tick = (tick_cnt_r == 8'(WDT_TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 8'h00;
    end else if (tick) begin
      tick_cnt_r <= 8'h00;
    end else begin
      tick_cnt_r <= tick_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r   <= 8'h00;
      wdt_cnt_r <= 8'h00;
    end else if (ex_op_r == OP_KICK) begin
      presc_r   <= 8'h00;
      wdt_cnt_r <= 8'h00;
    end else if (ctrl_r[CTRL_WDOG] && tick) begin
      presc_r <= presc_r + 8'h01;
      if (presc_r == 8'hFF) begin
        wdt_cnt_r <= wdt_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_kick    <= 1'b0;
      wdt_expired <= 1'b0;
    end else begin
      wdt_kick    <= (ex_op_r == OP_KICK);
      wdt_expired <= ctrl_r[CTRL_WDOG] && tick && presc_r == 8'hFF
                     && wdt_cnt_r == 8'hFF && ex_op_r != OP_KICK;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (apb_wr && paddr == ADDR_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (apb_setup) begin
        case (paddr)
          ADDR_CTRL:   prdata <= {30'h0, ctrl_r};
          ADDR_WREG:   prdata <= {24'h0, w_r};
          ADDR_STATUS: prdata <= {27'h0, status_r};
          ADDR_WDOG:   prdata <= {16'h0, presc_r, wdt_cnt_r};
          default:     pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_take_kick;
    instr_valid && ctrl_r[CTRL_EXEC] && instr == KICK_WORD;
  endsequence

  sequence s_take_any;
    instr_valid && ctrl_r[CTRL_EXEC] && dec_op != OP_NONE;
  endsequence

  property p_kick_decode;
    @(posedge pclk) disable iff (!presetn)
    s_take_kick |=> ex_op_r == OP_KICK;
  endproperty
  a_kick_decode: assert property (p_kick_decode) else $error("kick not decoded");

  property p_kick_counter;
    @(posedge pclk) disable iff (!presetn)
    s_take_kick ##1 1'b1 |=> wdt_cnt_r == 8'h00 && wdt_kick;
  endproperty
  a_kick_counter: assert property (p_kick_counter) else $error("counter not zeroed");

  property p_kick_presc;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_KICK |=> presc_r == 8'h00;
  endproperty
  a_kick_presc: assert property (p_kick_presc) else $error("prescaler not cleared");

  property p_kick_flags;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_KICK |=> status_r[ST_TIMEOUT] && status_r[ST_SLEEP]
      && $stable(status_r[2:0]);
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("kick flags wrong");

  property p_dec_file;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_DEC && ex_dest_r |=> freg_we && freg_wdata == $past(file_val) - 8'h01;
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

  property p_dec_w;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_DEC && !ex_dest_r |=> !freg_we && w_r == $past(file_val) - 8'h01;
  endproperty
  a_dec_w: assert property (p_dec_w) else $error("decrement to w wrong");

  property p_subl;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_SUBL |=> w_r == $past(ex_lit_r) - $past(w_r) && !freg_we;
  endproperty
  a_subl: assert property (p_subl) else $error("literal subtract wrong");

  property p_subf;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_SUBF && ex_dest_r |=> freg_we
      && freg_wdata == $past(file_val) - $past(w_r) && $stable(w_r);
  endproperty
  a_subf: assert property (p_subf) else $error("file subtract wrong");

  property p_carry;
    @(posedge pclk) disable iff (!presetn)
    ex_sub |=> status_r[ST_C] == ($past(alu_a) >= $past(w_r));
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");

  property p_half;
    @(posedge pclk) disable iff (!presetn)
    ex_sub |=> status_r[ST_HB] == ($past(alu_a[3:0]) >= $past(w_r[3:0]));
  endproperty
  a_half: assert property (p_half) else $error("half borrow wrong");

  property p_subl_decode;
    @(posedge pclk) disable iff (!presetn)
    instr_valid && ctrl_r[CTRL_EXEC] && instr[13:9] == SUBL_PREFIX |=> ex_op_r == OP_SUBL;
  endproperty
  a_subl_decode: assert property (p_subl_decode) else $error("literal op not decoded");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
    ex_op_r == OP_DEC || ex_sub |=> status_r[ST_Z] == ($past(alu_res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    s_take_any |=> ex_op_r != OP_NONE ##1 op_done;
  endproperty
  a_single: assert property (p_single) else $error("op not done in one cycle");

endmodule

// ===== rtl/wca_pkg.sv
package wca_pkg;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [13:0] KICK_WORD     = 14'h0064;
  localparam logic [5:0]  DEC_PREFIX    = 6'h03;
  localparam logic [5:0]  SUBF_PREFIX   = 6'h02;
  localparam logic [4:0]  SUBL_PREFIX   = 5'h1E;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_KICK = 3'b001,
    OP_DEC  = 3'b010,
    OP_SUBL = 3'b011,
    OP_SUBF = 3'b100
  } wca_op_e;

  // ----------------------------------------------------------------
  // status bit positions and reset value
  // ----------------------------------------------------------------
  localparam int          ST_C        = 0;
  localparam int          ST_HB       = 1;
  localparam int          ST_Z        = 2;
  localparam int          ST_SLEEP    = 3;
  localparam int          ST_TIMEOUT  = 4;
  localparam logic [4:0]  STATUS_RST  = 5'h18;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_WREG   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_WDOG   = 8'h0C;
  localparam logic [1:0]  CTRL_RST    = 2'h3;
  localparam int          CTRL_EXEC   = 0;
  localparam int          CTRL_WDOG   = 1;

  // ----------------------------------------------------------------
  // watchdog timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          WDT_TICK_NS   = 1000;
  localparam int          WDT_TICK_CYC  = WDT_TICK_NS / CLK_PERIOD_NS;

endpackage

// ===== rtl/wca_decode.sv
`timescale 1ns/10ps
module wca_decode
  import wca_pkg::*;
(
  input  wire logic [13:0]     instr,
  output wca_pkg::wca_op_e     op,
  output logic                 dest,
  output logic [6:0]           addr,
  output logic [7:0]           lit
);

  always_comb begin
    dest = instr[7];
    addr = instr[6:0];
    lit  = instr[7:0];
    if (instr == KICK_WORD) begin
      op = OP_KICK;
    end else if (instr[13:8] == DEC_PREFIX) begin
      op = OP_DEC;
    end else if (instr[13:9] == SUBL_PREFIX) begin
      op = OP_SUBL;
    end else if (instr[13:8] == SUBF_PREFIX) begin
      op = OP_SUBF;
    end else begin
      op = OP_NONE;
    end
  end

endmodule

// ===== rtl/wca_alu.sv
`timescale 1ns/10ps
module wca_alu
  import wca_pkg::*;
(
  input  wca_pkg::wca_op_e     op,
  input  wire logic [7:0]      a,
  input  wire logic [7:0]      w,
  output logic [7:0]           res,
  output logic                 carry,
  output logic                 half,
  output logic                 zero
);

  always_comb begin
    if (op == OP_DEC) begin
      res = a - 8'h01;
    end else begin
      res = a - w;
    end
    carry = (a >= w);
    half  = (a[3:0] >= w[3:0]);
    zero  = (res == 8'h00);
  end

endmodule

// ===== bench/wca_freg_model.sv
`timescale 1ns/10ps
module wca_freg_model (
  input  wire logic       pclk,
  input  wire logic [6:0] freg_raddr,
  output logic [7:0]      freg_rdata,
  input  wire logic       freg_we,
  input  wire logic [6:0] freg_waddr,
  input  wire logic [7:0] freg_wdata
);
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i ^ 8'hA5);
    end
  end
  // read path is combinational: the core samples it in the same cycle
  assign freg_rdata = mem[freg_raddr];
  always @(posedge pclk) begin
    if (freg_we === 1'b1) begin
      mem[freg_waddr] <= freg_wdata;
    end
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/10ps
module tb;
  import wca_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, freg_rdata, freg_wdata;
  logic [31:0] pwdata, prdata, rd;
  logic        instr_valid, freg_we, op_done, wdt_kick, wdt_expired;
  logic [13:0] instr;
  logic [6:0]  freg_raddr, freg_waddr;
  int          miscompares, compares, cycles, done_cnt, kick_cnt, n;

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  wca_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_valid(instr_valid), .instr(instr),
    .freg_raddr(freg_raddr), .freg_rdata(freg_rdata), .freg_we(freg_we),
    .freg_waddr(freg_waddr), .freg_wdata(freg_wdata), .op_done(op_done),
    .wdt_kick(wdt_kick), .wdt_expired(wdt_expired));
  wca_freg_model i_mem (.pclk(pclk), .freg_raddr(freg_raddr), .freg_rdata(freg_rdata),
    .freg_we(freg_we), .freg_waddr(freg_waddr), .freg_wdata(freg_wdata));

  // ----------------------------------------------------------------
  // monitors, hang guard and helpers
  // ----------------------------------------------------------------
  always @(negedge pclk) begin
    if (op_done === 1'b1) done_cnt++;
    if (wdt_kick === 1'b1) kick_cnt++;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until the edge that samples pready high; answer taken at that edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task send(input logic [13:0] w);
    @(posedge pclk);
    instr_valid <= 1'b1; instr <= w;
  endtask

  task finish_ops(input int want);
    int t;
    @(posedge pclk);
    instr_valid <= 1'b0;
    t = 0;
    while (done_cnt < want && t < 20) begin
      @(posedge pclk);
      t++;
    end
    @(posedge pclk);
    chk("op_done", 32'(done_cnt), 32'(want));
  endtask

  // returns {status, result} for op 0 decrement, 1 literal, 2 file subtract
  function automatic logic [12:0] expect_op(int op, logic [7:0] a, w, logic [2:0] s);
    logic [7:0] r;
    logic [4:0] st;
    r = a - ((op == 0) ? 8'h01 : w);
    st = {2'b11, s};
    st[ST_Z] = (r == 8'h00);
    if (op != 0) begin
      st[ST_C] = (a >= w);
      st[ST_HB] = (a[3:0] >= w[3:0]);
    end
    return {st, r};
  endfunction

  task run_op(input int op, input logic d, input logic [6:0] f, input logic [7:0] a,
              input logic [7:0] w, input logic [2:0] s);
    logic [12:0] e;
    logic        to_f;
    apb(1'b1, ADDR_WREG, {24'h0, w});
    apb(1'b1, ADDR_STATUS, {27'h0, 2'b11, s});
    i_mem.mem[f] = a;
    e = expect_op(op, a, w, s);
    to_f = d && (op != 1);
    case (op)
      0: send({DEC_PREFIX, d, f});
      1: send({SUBL_PREFIX, d, a});
      default: send({SUBF_PREFIX, d, f});
    endcase
    finish_ops(done_cnt + 1);
    apb(1'b0, ADDR_WREG, 32'h0);
    chk("w", rd, {24'h0, to_f ? w : e[7:0]});
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, {27'h0, e[12:8]});
    chk("freg", {24'h0, i_mem.mem[f]}, {24'h0, to_f ? e[7:0] : a});
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; instr_valid = 1'b0; instr = 14'h0000;
    void'($urandom(8));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, {30'h0, CTRL_RST});
    apb(1'b0, ADDR_WREG, 32'h0);
    chk("w", rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, {27'h0, STATUS_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    $display("test reset done");
    repeat (300) @(posedge pclk);
    apb(1'b1, ADDR_STATUS, 32'h07);
    n = kick_cnt + 1;
    send(KICK_WORD);
    finish_ops(done_cnt + 1);
    chk("kick", 32'(kick_cnt), 32'(n));
    apb(1'b0, ADDR_WDOG, 32'h0);
    chk("wdog", {16'h0, rd[15:0]}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h1F);
    chk("expired", {31'h0, wdt_expired}, 32'h0);
    $display("test kick done");
    // watchdog off so no expiry disturbs the status checks
    apb(1'b1, ADDR_CTRL, 32'h1);
    run_op(0, 1'b1, 7'h10, 8'h01, 8'h55, 3'h0);
    run_op(0, 1'b0, 7'h7F, 8'h00, 8'h55, 3'h7);
    run_op(1, 1'b0, 7'h00, 8'h02, 8'h02, 3'h0);
    run_op(1, 1'b1, 7'h01, 8'h02, 8'h03, 3'h7);
    run_op(1, 1'b0, 7'h02, 8'hFF, 8'h00, 3'h0);
    run_op(2, 1'b1, 7'h00, 8'h03, 8'h02, 3'h0);
    run_op(2, 1'b1, 7'h20, 8'h01, 8'h02, 3'h7);
    run_op(2, 1'b0, 7'h21, 8'h10, 8'h01, 3'h0);
    $display("test corners done");
    repeat (40) run_op($urandom % 3, 1'($urandom), 7'($urandom), 8'($urandom),
                       8'($urandom), 3'($urandom));
    $display("test random done");
    i_mem.mem[5] = 8'h03;
    send({DEC_PREFIX, 1'b1, 7'h05});
    send({DEC_PREFIX, 1'b1, 7'h05});
    finish_ops(done_cnt + 2);
    chk("b2b", {24'h0, i_mem.mem[5]}, 32'h1);
    $display("test back to back done");
    apb(1'b1, ADDR_CTRL, 32'h0);
    n = done_cnt;
    send({DEC_PREFIX, 1'b1, 7'h05});
    @(posedge pclk);
    instr_valid <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("idle", 32'(done_cnt), 32'(n));
    chk("idle freg", {24'h0, i_mem.mem[5]}, 32'h1);
    $display("test disabled done");
    print_verdict();
  end
endmodule
